// >>> verilog/sfhc_top.sv
// Host controller that frames commands to a serial NOR flash.
// Assumes a flash on cs/sck/four lanes; the board resolves the lanes.
//
// Notes on behaviour
// - Page program sends 1 to 256 bytes.
// - Quad program needs quad enable and latch.
// - Quad program opcode single lane, rest quad.
// - Suspend is opcode B0H in one frame.
// - At least 500 us between suspends.
// - After suspend, poll busy before next command.
// - ID read: two address bytes, then dummies.
// - ID program: latch, 1 to 256 bytes.
// - Register write sends two bytes, second counts.
// - Latch set precedes every write-class command.
`timescale 1ns/1ps
module sfhc_top #(
   parameter int P_SUSP_GAP_CYC = sfhc_pkg::SUSPEND_GAP_CYC,
   parameter int P_SCK_HALF = sfhc_pkg::SCK_HALF_CYC
) (
   input logic i_clk,
   input logic i_reset,
   input logic i_req_valid,
   input sfhc_pkg::sfhc_req_t i_req,
   output logic o_req_ready,
   input logic i_wr_valid,
   input logic [7:0] i_wr_data,
   output logic o_wr_ready,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_done,
   output logic o_refused,
   output logic [7:0] o_status,
   output logic o_wel,
   output logic o_quad_en,
   output logic o_cs_n,
   output logic o_sck,
   input logic [3:0] i_sio,
   output logic [3:0] o_sio,
   output logic [3:0] o_sio_oe
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} sfhc_st_t;
   typedef enum logic [2:0] {
      PH_OPC, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_END
   } sfhc_ph_t;

   typedef struct packed {
      sfhc_st_t st;
      sfhc_ph_t ph;
      logic [7:0] op;
      logic [7:0] uop;
      logic sqi;
      sfhc_pkg::sfhc_dec_t dec;
      logic [8:0] ucnt;
      logic [2:0] bitc;
      logic [7:0] sh;
      logic [23:0] adr;
      logic need_wr;
      logic wel;
      logic poll;
      logic wclass;
      logic npoll;
      logic cs_n;
      logic done;
      logic refused;
      logic rd_valid;
      logic [7:0] rd_data;
      logic [7:0] cfg;
      logic [7:0] stat;
      logic [3:0] gapc;
      logic [13:0] suspc;
   } sfhc_state_t;

   localparam logic [13:0] SUSP_LOAD = 14'(P_SUSP_GAP_CYC - 1);

   if (P_SUSP_GAP_CYC < 1 || P_SUSP_GAP_CYC > 16383) begin : g_bad_gap
      $error("sfhc_top: P_SUSP_GAP_CYC out of range 1..16383");
   end

   sfhc_state_t q;
   sfhc_state_t d;
   sfhc_pkg::sfhc_dec_t req_dec;
   logic refuse;
   logic qlane;
   logic [7:0] sh_shift;
   logic [3:0] sio_s;
   logic sck_fall;
   logic run;

   // ----------------------------------------------------------------
   // Command decoding
   // ----------------------------------------------------------------
   function automatic sfhc_pkg::sfhc_dec_t decode(input logic [7:0] op,
      input logic sqi, input logic [8:0] len);
      sfhc_pkg::sfhc_dec_t r;
      logic len_ok;
      r = '0;
      len_ok = (len != 9'h000) && (len <= 9'(sfhc_pkg::PAGE_BYTES));
      r.oquad = sqi;
      r.qbody = sqi;
      case (op)
         sfhc_pkg::OP_LATCH_SET, sfhc_pkg::OP_LATCH_CLEAR: r.ok = 1'b1;
         sfhc_pkg::OP_PAGE_PROG, sfhc_pkg::OP_QUAD_PROG:
         begin
            r.ok = len_ok;
            r.nadr = sfhc_pkg::ADDR_BYTES;
            r.nwr = len;
            r.wclass = 1'b1;
            r.poll = 1'b1;
            if (op == sfhc_pkg::OP_QUAD_PROG)
            begin
               r.oquad = 1'b0;
               r.qbody = 1'b1;
            end
         end
         sfhc_pkg::OP_SUSPEND, sfhc_pkg::OP_RESUME:
         begin
            r.ok = 1'b1;
            r.poll = 1'b1;
         end
         sfhc_pkg::OP_SID_READ:
         begin
            r.ok = (len != 9'h000);
            r.nadr = sfhc_pkg::SID_ADDR_BYTES;
            r.ndum = sqi ? 2'h3 : 2'h1;
            r.nrd = len;
         end
         sfhc_pkg::OP_SID_PROG:
         begin
            r.ok = len_ok;
            r.nadr = sfhc_pkg::SID_ADDR_BYTES;
            r.nwr = len;
            r.wclass = 1'b1;
            r.poll = 1'b1;
         end
         sfhc_pkg::OP_SID_LOCK:
         begin
            r.ok = 1'b1;
            r.wclass = 1'b1;
            r.poll = 1'b1;
         end
         sfhc_pkg::OP_STATUS_READ, sfhc_pkg::OP_CONFIG_READ:
         begin
            r.ok = (len != 9'h000);
            r.ndum = sqi ? 2'h1 : 2'h0;
            r.nrd = len;
         end
         sfhc_pkg::OP_REG_WRITE:
         begin
            r.ok = 1'b1;
            r.nwr = sfhc_pkg::REG_WRITE_BYTES;
            r.wclass = 1'b1;
            r.poll = 1'b1;
         end
         default: r.ok = 1'b0;
      endcase
      return r;
   endfunction : decode

   function automatic sfhc_ph_t next_ph(input sfhc_ph_t cur,
      input sfhc_pkg::sfhc_dec_t r);
      sfhc_ph_t n;
      n = PH_END;
      if (cur == PH_OPC && r.nadr != 2'h0)
         n = PH_ADDR;
      else if (cur <= PH_ADDR && r.ndum != 2'h0)
         n = PH_DUMMY;
      else if (cur <= PH_DUMMY && r.nwr != 9'h000)
         n = PH_WDATA;
      else if (cur <= PH_WDATA && r.nrd != 9'h000)
         n = PH_RDATA;
      return n;
   endfunction : next_ph

   // ----------------------------------------------------------------
   // Unit and phase sequencing
   // ----------------------------------------------------------------
   function automatic sfhc_state_t begin_unit(input sfhc_state_t s,
      input sfhc_ph_t ph);
      sfhc_state_t r;
      logic quad;
      r = s;
      r.ph = ph;
      quad = (ph == PH_OPC) ? s.dec.oquad : s.dec.qbody;
      r.bitc = quad ? 3'h1 : 3'h7;
      case (ph)
         PH_OPC: r.sh = s.op;
         PH_ADDR:
         begin
            r.sh = s.adr[23:16];
            r.adr = {s.adr[15:0], 8'h00};
         end
         PH_WDATA: r.need_wr = 1'b1;
         default: r.sh = 8'h00;
      endcase
      return r;
   endfunction : begin_unit

   function automatic sfhc_state_t enter(input sfhc_state_t s,
      input sfhc_ph_t ph);
      sfhc_state_t r;
      r = s;
      case (ph)
         PH_ADDR: r.ucnt = {7'h00, s.dec.nadr} - 9'h001;
         PH_DUMMY: r.ucnt = {7'h00, s.dec.ndum} - 9'h001;
         PH_WDATA: r.ucnt = s.dec.nwr - 9'h001;
         PH_RDATA: r.ucnt = s.dec.nrd - 9'h001;
         default: r.ucnt = '0;
      endcase
      if (ph == PH_END)
      begin
         r.ph = PH_END;
         r.st = ST_GAP;
         r.cs_n = 1'b1;
         r.gapc = sfhc_pkg::CS_GAP_CYC;
      end
      else
      begin
         r = begin_unit(r, ph);
      end
      return r;
   endfunction : enter

   function automatic sfhc_state_t launch(input sfhc_state_t s,
      input logic [7:0] op, input logic sqi, input logic [8:0] len,
      input logic [23:0] addr, input logic poll);
      sfhc_state_t r;
      r = s;
      r.dec = decode(op, sqi, len);
      r.op = op;
      r.sqi = sqi;
      r.poll = poll;
      r.adr = (r.dec.nadr == sfhc_pkg::SID_ADDR_BYTES) ?
         {addr[15:0], 8'h00} : addr;
      r.st = ST_SHIFT;
      r.cs_n = 1'b0;
      r = enter(r, PH_OPC);
      return r;
   endfunction : launch

   // ----------------------------------------------------------------
   // Pins and clock
   // ----------------------------------------------------------------
   sfhc_sync #(.W(4)) u_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async(i_sio),
      .o_sync(sio_s)
   );

   assign run = (q.st == ST_SHIFT) && !q.need_wr;

   sfhc_sckgen #(.HALF(P_SCK_HALF)) u_sck (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_run(run),
      .o_sck(o_sck),
      .o_rise(),
      .o_fall(sck_fall)
   );

   assign qlane = (q.ph == PH_OPC) ? q.dec.oquad : q.dec.qbody;

   always_comb
   begin
      if (q.ph == PH_RDATA)
         sh_shift = qlane ? {q.sh[3:0], sio_s} : {q.sh[6:0], sio_s[1]};
      else
         sh_shift = qlane ? {q.sh[3:0], 4'h0} : {q.sh[6:0], 1'b0};
   end

   always_comb
   begin
      if (q.st == ST_SHIFT && qlane)
      begin
         o_sio = q.sh[7:4];
         o_sio_oe = (q.ph inside {PH_OPC, PH_ADDR, PH_WDATA}) ?
            4'hF : 4'h0;
      end
      else
      begin
         o_sio = {2'b11, 1'b0, q.sh[7]};
         o_sio_oe = 4'hD;
      end
   end

   // ----------------------------------------------------------------
   // Request acceptance
   // ----------------------------------------------------------------
   assign req_dec = decode(i_req.opcode, i_req.sqi, i_req.len);
   assign refuse = !req_dec.ok
      || (req_dec.wclass && !q.wel)
      || (i_req.opcode == sfhc_pkg::OP_QUAD_PROG
         && !q.cfg[sfhc_pkg::QE_BIT])
      || (i_req.opcode == sfhc_pkg::OP_SUSPEND && q.suspc != '0);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      d.refused = 1'b0;
      d.rd_valid = 1'b0;
      if (q.suspc != '0)
         d.suspc = q.suspc - 14'h0001;
      case (q.st)
         ST_IDLE:
         begin
            if (i_req_valid && refuse)
            begin
               d.done = 1'b1;
               d.refused = 1'b1;
            end
            else if (i_req_valid)
            begin
               d = launch(d, i_req.opcode, i_req.sqi, i_req.len,
                  i_req.addr, 1'b0);
               d.uop = i_req.opcode;
               d.wclass = req_dec.wclass;
               d.npoll = req_dec.poll;
               if (i_req.opcode == sfhc_pkg::OP_SUSPEND)
                  d.suspc = SUSP_LOAD;
            end
         end
         ST_SHIFT:
         begin
            if (q.need_wr)
            begin
               if (i_wr_valid)
               begin
                  d.sh = i_wr_data;
                  d.need_wr = 1'b0;
                  if (q.op == sfhc_pkg::OP_REG_WRITE && q.ucnt == '0)
                     d.cfg = i_wr_data;
               end
            end
            else if (sck_fall)
            begin
               d.sh = sh_shift;
               if (q.bitc != 3'h0)
               begin
                  d.bitc = q.bitc - 3'h1;
               end
               else
               begin
                  if (q.ph == PH_RDATA && q.poll)
                  begin
                     d.stat = sh_shift;
                  end
                  else if (q.ph == PH_RDATA)
                  begin
                     d.rd_data = sh_shift;
                     d.rd_valid = 1'b1;
                     if (q.op == sfhc_pkg::OP_CONFIG_READ)
                        d.cfg = sh_shift;
                  end
                  if (q.ph != PH_OPC && q.ucnt != '0)
                  begin
                     d.ucnt = q.ucnt - 9'h001;
                     d = begin_unit(d, q.ph);
                  end
                  else
                  begin
                     d = enter(d, next_ph(q.ph, q.dec));
                  end
               end
            end
         end
         ST_GAP:
         begin
            if (q.gapc != 4'h0)
            begin
               d.gapc = q.gapc - 4'h1;
            end
            else if (q.poll && q.stat[sfhc_pkg::BUSY_BIT])
            begin
               d = launch(d, sfhc_pkg::OP_STATUS_READ, q.sqi, 9'h001,
                  '0, 1'b1);
            end
            else if (!q.poll && q.npoll)
            begin
               if (q.uop == sfhc_pkg::OP_LATCH_CLEAR)
                  d.wel = 1'b0;
               d = launch(d, sfhc_pkg::OP_STATUS_READ, q.sqi, 9'h001,
                  '0, 1'b1);
            end
            else
            begin
               if (q.uop == sfhc_pkg::OP_LATCH_SET && !q.poll)
                  d.wel = 1'b1;
               if ((q.uop == sfhc_pkg::OP_LATCH_CLEAR && !q.poll)
                  || (q.poll && q.wclass))
                  d.wel = 1'b0;
               d.st = ST_IDLE;
               d.done = 1'b1;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         q <= '0;
         q.cs_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_req_ready = (q.st == ST_IDLE);
   assign o_wr_ready = (q.st == ST_SHIFT) && q.need_wr;
   assign o_rd_valid = q.rd_valid;
   assign o_rd_data = q.rd_data;
   assign o_done = q.done;
   assign o_refused = q.refused;
   assign o_status = q.stat;
   assign o_wel = q.wel;
   assign o_quad_en = q.cfg[sfhc_pkg::QE_BIT];
   assign o_cs_n = q.cs_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_page_len;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && !q.poll && q.op == sfhc_pkg::OP_PAGE_PROG)
      |-> (q.dec.nwr != 9'h000 && q.dec.nwr <= 9'h100);
   endproperty
   a_page_len: assert property (p_page_len)
      else $error("page program length outside 1..256");

   property p_quad_ready;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && !q.poll && q.op == sfhc_pkg::OP_QUAD_PROG)
      |-> (q.cfg[sfhc_pkg::QE_BIT] && q.wel);
   endproperty
   a_quad_ready: assert property (p_quad_ready)
      else $error("quad program without quad enable and latch");

   property p_quad_lanes;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && q.op == sfhc_pkg::OP_QUAD_PROG
         && q.ph inside {PH_ADDR, PH_WDATA} && !q.need_wr)
      |-> (o_sio_oe == 4'hF && q.bitc <= 3'h1);
   endproperty
   a_quad_lanes: assert property (p_quad_lanes)
      else $error("quad program body not on four lanes");

   property p_quad_opcode;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && q.op == sfhc_pkg::OP_QUAD_PROG
         && q.ph == PH_OPC) |-> o_sio_oe == 4'hD;
   endproperty
   a_quad_opcode: assert property (p_quad_opcode)
      else $error("quad program opcode not single lane");

   property p_sck_framed;
      @(posedge i_clk) disable iff (i_reset)
      o_cs_n |-> !o_sck;
   endproperty
   a_sck_framed: assert property (p_sck_framed)
      else $error("serial clock high while deselected");

   property p_susp_gap;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_IDLE && i_req_valid && q.suspc != '0
         && i_req.opcode == sfhc_pkg::OP_SUSPEND)
      |=> (o_refused && o_done && o_cs_n);
   endproperty
   a_susp_gap: assert property (p_susp_gap)
      else $error("suspend issued too soon");

   property p_susp_poll;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_GAP && q.gapc == 4'h0 && !q.poll
         && q.uop == sfhc_pkg::OP_SUSPEND)
      |=> (q.st == ST_SHIFT && q.poll && !o_cs_n
         && q.op == sfhc_pkg::OP_STATUS_READ);
   endproperty
   a_susp_poll: assert property (p_susp_poll)
      else $error("suspend not followed by busy poll");

   property p_sid_dummy;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && q.op == sfhc_pkg::OP_SID_READ
         && q.ph == PH_DUMMY) |-> (q.ucnt <= (q.sqi ? 9'h002 : 9'h000));
   endproperty
   a_sid_dummy: assert property (p_sid_dummy)
      else $error("wrong dummy count on ID read");

   property p_sid_prog;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && !q.poll && q.op == sfhc_pkg::OP_SID_PROG)
      |-> (q.wel && q.dec.nwr != 9'h000 && q.dec.nwr <= 9'h100);
   endproperty
   a_sid_prog: assert property (p_sid_prog)
      else $error("ID program without latch or bad length");

   property p_reg_write;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && !q.poll && q.op == sfhc_pkg::OP_REG_WRITE)
      |-> (q.dec.nwr == 9'h002 && q.wel);
   endproperty
   a_reg_write: assert property (p_reg_write)
      else $error("register write framing wrong");

   property p_latch_first;
      @(posedge i_clk) disable iff (i_reset)
      (q.st == ST_SHIFT && !q.poll && q.dec.wclass) |-> q.wel;
   endproperty
   a_latch_first: assert property (p_latch_first)
      else $error("write-class command without latch set");
endmodule : sfhc_top

// >>> pkg/sfhc_pkg.sv
// Constants, opcodes and carrier types of the serial flash host controller.
// Assumes a 20 MHz system clock and a flash in single-lane or quad mode.
package sfhc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int SUSPEND_GAP_US = 500;
   localparam int SUSPEND_GAP_CYC = SUSPEND_GAP_US * CLK_MHZ;
   localparam int SCK_HALF_CYC = 4;
   localparam logic [3:0] CS_GAP_CYC = 4'h2;

   // ----------------------------------------------------------------
   // Framing and register fields
   // ----------------------------------------------------------------
   localparam int PAGE_BYTES = 256;
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [1:0] SID_ADDR_BYTES = 2'h2;
   localparam logic [8:0] REG_WRITE_BYTES = 9'h002;
   localparam int BUSY_BIT = 0;
   localparam int QE_BIT = 1;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG = 8'h32;
   localparam logic [7:0] OP_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME = 8'h30;
   localparam logic [7:0] OP_SID_READ = 8'h88;
   localparam logic [7:0] OP_SID_PROG = 8'hA5;
   localparam logic [7:0] OP_SID_LOCK = 8'h85;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CONFIG_READ = 8'h35;
   localparam logic [7:0] OP_REG_WRITE = 8'h01;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [8:0] len;
      logic sqi;
   } sfhc_req_t;

   typedef struct packed {
      logic ok;
      logic wclass;
      logic poll;
      logic oquad;
      logic qbody;
      logic [1:0] nadr;
      logic [1:0] ndum;
      logic [8:0] nwr;
      logic [8:0] nrd;
   } sfhc_dec_t;

endpackage : sfhc_pkg

// >>> verilog/sfhc_sync.sv
// Two-flop synchroniser for the flash data lanes.
// Assumes the lanes change asynchronously to i_clk.
`timescale 1ns/1ps
module sfhc_sync #(
   parameter int W = 4
) (
   input logic i_clk,
   input logic i_reset,
   input logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfhc_sync_state_t;

   sfhc_sync_state_t q;
   sfhc_sync_state_t d;

   if (W < 1) begin : g_bad_w
      $error("sfhc_sync: W must be at least 1");
   end

   always_comb
   begin
      d.s1 = i_async;
      d.s2 = q.s1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_sync = q.s2;
endmodule : sfhc_sync

// >>> verilog/sfhc_sckgen.sv
// Serial clock divider: idles low, toggles every HALF cycles while run.
// Assumes run drops only right after a falling edge.
`timescale 1ns/1ps
module sfhc_sckgen #(
   parameter int HALF = 4
) (
   input logic i_clk,
   input logic i_reset,
   input logic i_run,
   output logic o_sck,
   output logic o_rise,
   output logic o_fall
);
   localparam int CW = $clog2(HALF + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic sck;
   } sfhc_sck_state_t;

   sfhc_sck_state_t q;
   sfhc_sck_state_t d;
   logic tick;

   if (HALF < 3) begin : g_bad_half
      $error("sfhc_sckgen: HALF below 3 outruns the input synchroniser");
   end

   assign tick = i_run && (q.cnt == CW'(HALF - 1));

   always_comb
   begin
      d = q;
      if (!i_run)
      begin
         d.cnt = '0;
      end
      else if (tick)
      begin
         d.cnt = '0;
         d.sck = !q.sck;
      end
      else
      begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_sck = q.sck;
   assign o_rise = tick && !q.sck;
   assign o_fall = tick && q.sck;
endmodule : sfhc_sckgen

// >>> tb/sfhc_flash_model.sv
// Behavioural serial flash answering the host controller in single lane.
// Assumes mode 0 frames; released lanes are pulled up by the bench.
`timescale 1ns/1ps
module sfhc_flash_model (
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic [3:0] i_sio,
   output logic [3:0] o_sio,
   output logic [3:0] o_oe
);
   logic [31:0] sh;
   logic [15:0] ad;
   logic [7:0] op, cr, rb, pa, sp;
   logic [7:0] pg [256];
   logic wel, susp, rd, lock, ign;
   int n = 0;
   int busy = 0;
   initial
   begin
      {wel, susp, lock, cr, o_oe, o_sio} = '0;
   end
   always @(negedge i_cs_n) n = 0;
   always @(posedge i_sck)
   begin
      sh = {sh[30:0], i_sio[0]};
      n = n + 1;
      if (n == 8) op = sh[7:0];
      if (n == 24) ad = sh[15:0];
      if (n == 24 && op == 8'h02) pa = sh[15:8];
      if (n == 32 && op == 8'h02) ad = sh[15:0];
      // Last 256 bytes kept, wrapping inside the page
      if (n >= 40 && n % 8 == 0 && op == 8'h02)
         pg[8'(ad[7:0] + (n - 40) / 8)] = sh[7:0];
   end
   // Read bytes leave on falling edges until deselect
   always @(negedge i_sck)
   begin
      rb = (op == 8'h05) ? {7'h0, busy != 0} : (op == 8'h35) ? cr
         : ad[7:0] + 8'((n - 32) / 8);
      rd = op == 8'h05 || op == 8'h35 || (op == 8'h88 && n >= 32);
      o_oe = {2'h0, rd && n >= 8, 1'b0};
      o_sio = {2'h0, rb[7 - (n % 8)], 1'b0};
   end
   always @(posedge i_cs_n)
   begin
      o_oe = 4'h0;
      if (op == 8'h05 && busy > 0) busy = busy - 1;
      if (op == 8'h06) wel = 1;
      if (op == 8'h04 && busy == 0) wel = 0;
      if (wel && (op inside {8'h02, 8'h32, 8'h01, 8'hA5, 8'h85}))
      begin
         if (op == 8'h01) cr = sh[7:0];
         // Protected, locked or suspended targets are dropped
         ign = (op == 8'hA5 && (lock || ad < 16'h0008))
            || (op == 8'h02 && pa == 8'hFF)
            || (susp && op == 8'h02 && ad[15:8] == sp);
         if (op == 8'h85) lock = 1;
         busy = ign ? 0 : 3;
         wel = 0;
      end
      if (op == 8'hB0 && !susp)
      begin
         susp = 1;
         sp = ad[15:8];
         busy = 1;
      end
      if (op == 8'h30 && susp && busy == 0)
      begin
         susp = 0;
         busy = 1;
      end
   end
endmodule : sfhc_flash_model

// >>> tb/tb_sfhc_top.sv
// Self-checking bench of the serial flash host controller.
// Assumes the behavioural flash on the lanes, lanes pulled up.
`timescale 1ns/1ps
module tb_sfhc_top;
   logic i_clk, i_reset, i_req_valid, i_wr_valid, o_req_ready, o_wr_ready;
   logic o_rd_valid, o_done, o_refused, o_wel, o_quad_en, o_cs_n, o_sck;
   logic [7:0] i_wr_data, o_rd_data, o_status, rd_last, wr_last;
   logic [3:0] i_sio, o_sio, o_sio_oe, f_sio, f_oe;
   logic [23:0] ad;
   logic took;
   sfhc_pkg::sfhc_req_t i_req;
   int seed = 60294;
   int n_mismatch = 0;
   int samples_checked = 0;
   sfhc_top #(.P_SUSP_GAP_CYC(2000), .P_SCK_HALF(4)) dut (.i_clk(i_clk),
      .i_reset(i_reset), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .i_wr_valid(i_wr_valid),
      .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_done(o_done),
      .o_refused(o_refused), .o_status(o_status), .o_wel(o_wel),
      .o_quad_en(o_quad_en), .o_cs_n(o_cs_n), .o_sck(o_sck),
      .i_sio(i_sio), .o_sio(o_sio), .o_sio_oe(o_sio_oe));
   sfhc_flash_model flash (.i_cs_n(o_cs_n), .i_sck(o_sck), .i_sio(i_sio),
      .o_sio(f_sio), .o_oe(f_oe));
   always_comb
      for (int k = 0; k < 4; k++)
         i_sio[k] = o_sio_oe[k] ? o_sio[k] : f_oe[k] ? f_sio[k] : 1'b1;
   initial
   begin
      i_clk = 0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      if (o_rd_valid) rd_last <= o_rd_data;
      if (o_wr_ready && i_wr_valid) wr_last <= i_wr_data;
      took <= o_wr_ready && i_wr_valid;
   end
   // Fresh byte and valid once the last one was taken or none was offered
   always @(negedge i_clk)
      if (took || !i_wr_valid)
      begin
         i_wr_data = 8'($random(seed));
         i_wr_valid = 1'($random(seed));
      end
   // Last byte of an ID read streamed from address a
   function automatic logic [7:0] sid_last(input logic [23:0] a,
      input int len);
      return a[7:0] + 8'(len - 1);
   endfunction : sid_last
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic finish_test();
      $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // Issue one command, wait for completion, check the refusal flag
   task automatic run(input logic [7:0] op, input logic [8:0] len,
      input logic rf);
      int k;
      @(negedge i_clk);
      i_req = '{op, ad, len, 1'b0};
      i_req_valid = 1;
      @(negedge i_clk);
      i_req_valid = 0;
      for (k = 0; k < 20000 && o_done !== 1'b1; k++) @(negedge i_clk);
      if (k == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
      cmp(8'(o_refused), 8'(rf));
      $display("test op=%h done", op);
   endtask : run
   initial
   begin
      i_reset = 1;
      i_req_valid = 0;
      i_wr_valid = 1;
      i_wr_data = 8'h00;
      i_req = '0;
      ad = 24'h00_00F0;
      repeat (6) @(negedge i_clk);
      i_reset = 0;
      cmp(8'(o_cs_n), 8'h01);
      run(8'h02, 9'h004, 1);
      run(8'h06, 9'h000, 0);
      cmp(8'(o_wel), 8'h01);
      run(8'h04, 9'h000, 0);
      cmp(8'(o_wel), 8'h00);
      run(8'h06, 9'h000, 0);
      run(8'h32, 9'h001, 1);
      run(8'h01, 9'h002, 0);
      cmp(8'(o_quad_en), 8'(wr_last[1]));
      cmp(8'(o_wel), 8'h00);
      cmp(8'(o_status[0]), 8'h00);
      run(8'h35, 9'h001, 0);
      cmp(rd_last, wr_last);
      run(8'h06, 9'h000, 0);
      run(8'h32, 9'h001, !wr_last[1]);
      repeat (4)
      begin
         ad = 24'($random(seed));
         run(8'h06, 9'h000, 0);
         run(8'h02, 9'(1 + ($random(seed) & 3)), 0);
         cmp(8'(o_wel), 8'h00);
      end
      run(8'h06, 9'h000, 0);
      run(8'h02, 9'h000, 1);
      run(8'h02, 9'h101, 1);
      run(8'hB0, 9'h000, 0);
      run(8'hB0, 9'h000, 1);
      run(8'h30, 9'h000, 0);
      ad = 24'h00_0123;
      run(8'h06, 9'h000, 0);
      run(8'hA5, 9'h002, 0);
      cmp(8'(o_wel), 8'h00);
      run(8'h06, 9'h000, 0);
      run(8'h85, 9'h000, 0);
      run(8'h88, 9'h003, 0);
      cmp(rd_last, sid_last(ad, 3));
      finish_test();
   end
endmodule : tb_sfhc_top
